// >>> rtl/tsbsc_defines.svh
/*
 Constants of the temperature sensor serial slave and standby control:
 command codes, bit positions, power-on values and timing counts.
 Assumes a 100 MHz core clock; included by bare name.
*/
`ifndef TSBSC_DEFINES_SVH
`define TSBSC_DEFINES_SVH

// Timing.
`define TSBSC_CLK_HZ          100000000
`define TSBSC_CONV_TIME_MS    125
`define TSBSC_CONV_CYCLES     (`TSBSC_CONV_TIME_MS * (`TSBSC_CLK_HZ / 1000))
`define TSBSC_RATE_TIME_MS    1000
`define TSBSC_RATE_CYCLES     (`TSBSC_RATE_TIME_MS * (`TSBSC_CLK_HZ / 1000))

// Addresses. The slave address default is arbitrary.
`define TSBSC_ARA_ADDR        7'h0c
`define TSBSC_SLAVE_ADDR_DFLT 7'h2a

// Command codes.
`define TSBSC_CMD_RD_LOCAL    8'h00
`define TSBSC_CMD_RD_REMOTE   8'h01
`define TSBSC_CMD_RD_STATUS   8'h02
`define TSBSC_CMD_RD_CFG      8'h03
`define TSBSC_CMD_RD_RATE     8'h04
`define TSBSC_CMD_RD_LHI      8'h05
`define TSBSC_CMD_RD_LLO      8'h06
`define TSBSC_CMD_RD_RHI      8'h07
`define TSBSC_CMD_RD_RLO      8'h08
`define TSBSC_CMD_WR_CFG      8'h09
`define TSBSC_CMD_WR_RATE     8'h0a
`define TSBSC_CMD_WR_LHI      8'h0b
`define TSBSC_CMD_WR_LLO      8'h0c
`define TSBSC_CMD_WR_RHI      8'h0d
`define TSBSC_CMD_WR_RLO      8'h0e
`define TSBSC_CMD_ONESHOT     8'h0f

// Field positions.
`define TSBSC_CFG_MASK_BIT    7
`define TSBSC_CFG_HALT_BIT    6
`define TSBSC_ST_BUSY_BIT     7
`define TSBSC_ST_LHI_BIT      6
`define TSBSC_ST_LLO_BIT      5
`define TSBSC_ST_RHI_BIT      4
`define TSBSC_ST_RLO_BIT      3

// Power-on values.
`define TSBSC_CFG_POR         8'h00
`define TSBSC_RATE_POR        8'h02
`define TSBSC_THI_POR         8'h7f
`define TSBSC_TLO_POR         8'hc9
`define TSBSC_TEMP_POR        8'h00
`define TSBSC_RD_DFLT         8'h00

// Result rounding and clamping, quarter-degree input.
`define TSBSC_ROUND_HALF      12'sh002
`define TSBSC_CLAMP_HI        10'sh07f
`define TSBSC_CLAMP_LO        10'sh3bf

`endif

// >>> rtl/tsbsc_pkg.sv
/*
 Types of the temperature sensor serial slave and standby control.
 Assumes nothing of its surroundings.
*/
package tsbsc_pkg;
  typedef logic [7:0] tsbsc_byte_t;

  typedef enum logic [4:0] {
    L_ADDR   = 5'h01,
    L_CMD    = 5'h02,
    L_DATA   = 5'h04,
    L_TX     = 5'h08,
    L_IGNORE = 5'h10
  } tsbsc_lstate_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'h1,
    C_BUSY = 2'h2
  } tsbsc_cstate_t;
endpackage : tsbsc_pkg

// >>> rtl/tsbsc_link_if.sv
/*
 Carrier between the serial bit engine (serial clock domain) and the core.
 Assumes toggles are synchronised by the receiver; bytes beside a toggle are
 held stable until the next toggle, and rd_byte is held stable within a frame except on a command byte.
*/
`timescale 1ns/1ps
`default_nettype none
interface tsbsc_link_if;
  logic                 frame_rst_n;
  logic                 cmd_tgl;
  logic                 dat_tgl;
  logic                 ara_tgl;
  tsbsc_pkg::tsbsc_byte_t cmd_byte;
  tsbsc_pkg::tsbsc_byte_t dat_byte;
  tsbsc_pkg::tsbsc_byte_t rd_byte;
  logic                 alert_lvl;
  logic                 sda_oe;

  modport engine (
    input  frame_rst_n, rd_byte, alert_lvl,
    output cmd_tgl, dat_tgl, ara_tgl, cmd_byte, dat_byte, sda_oe
  );
  modport core (
    output frame_rst_n, rd_byte, alert_lvl,
    input  cmd_tgl, dat_tgl, ara_tgl, cmd_byte, dat_byte, sda_oe
  );
endinterface : tsbsc_link_if
`default_nettype wire

// >>> rtl/tsbsc_link.sv
/*
 Serial bit engine on the serial clock: samples data on the rising edge,
 drives acknowledge and read data on the falling edge.
 Assumes the core holds it in reset from every start or stop until the clock
 goes low, so that each frame begins with a clean bit count.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tsbsc_defines.svh"
module tsbsc_link #(
  parameter logic [6:0] SLAVE_ADDR = `TSBSC_SLAVE_ADDR_DFLT
) (
  // Clock and reset
  input  wire logic smb_clk_i,
  input  wire logic rst_n_i,
  // Serial data level
  input  wire logic smb_data_i,
  // Core side
  tsbsc_link_if.engine lnk
);
  tsbsc_pkg::tsbsc_lstate_t state_r, state_nxt;
  logic [3:0]             cnt_r, cnt_nxt;
  logic [7:0]             shift_r, shift_nxt, byte_w;
  logic                   ack_r, ack_nxt, rw_r, rw_nxt, ara_r, ara_nxt;
  logic [7:0]             cmd_r, cmd_nxt, dat_r, dat_nxt, tx_r, tx_nxt, tx_src;
  logic                   ctg_r, ctg_nxt, dtg_r, dtg_nxt, atg_r, atg_nxt;
  logic                   drv_r, drv_nxt, alert_m_r, alert_s_r;
  logic                   eng_rst_n;

  assign eng_rst_n    = rst_n_i & lnk.frame_rst_n;
  assign byte_w       = {shift_r[6:0], smb_data_i};
  assign tx_src       = ara_r ? {SLAVE_ADDR, 1'b1} : lnk.rd_byte;
  assign lnk.cmd_tgl  = ctg_r;
  assign lnk.dat_tgl  = dtg_r;
  assign lnk.ara_tgl  = atg_r;
  assign lnk.cmd_byte = cmd_r;
  assign lnk.dat_byte = dat_r;
  assign lnk.sda_oe   = drv_r;

  // Toggles must survive frame resets, so they use the plain reset only.
  always_ff @(posedge smb_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctg_r     <= 1'b0;
      dtg_r     <= 1'b0;
      atg_r     <= 1'b0;
      cmd_r     <= 8'h00;
      dat_r     <= 8'h00;
      alert_m_r <= 1'b0;
      alert_s_r <= 1'b0;
    end else begin
      ctg_r     <= ctg_nxt;
      dtg_r     <= dtg_nxt;
      atg_r     <= atg_nxt;
      cmd_r     <= cmd_nxt;
      dat_r     <= dat_nxt;
      alert_m_r <= lnk.alert_lvl;
      alert_s_r <= alert_m_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    ack_nxt   = ack_r;
    rw_nxt    = rw_r;
    ara_nxt   = ara_r;
    cmd_nxt   = cmd_r;
    dat_nxt   = dat_r;
    ctg_nxt   = ctg_r;
    dtg_nxt   = dtg_r;
    atg_nxt   = atg_r;
    if (cnt_r == 4'd8) begin
      cnt_nxt = 4'd0;
      ack_nxt = 1'b0;
      case (state_r)
        tsbsc_pkg::L_ADDR: begin
          if (!ack_r) begin
            state_nxt = tsbsc_pkg::L_IGNORE;
          end else if (rw_r) begin
            state_nxt = tsbsc_pkg::L_TX;
            atg_nxt   = atg_r ^ ara_r;
          end else begin
            state_nxt = tsbsc_pkg::L_CMD;
          end
        end
        tsbsc_pkg::L_CMD:    state_nxt = tsbsc_pkg::L_DATA;
        tsbsc_pkg::L_DATA:   state_nxt = tsbsc_pkg::L_IGNORE;
        tsbsc_pkg::L_TX:     state_nxt = smb_data_i ? tsbsc_pkg::L_IGNORE : tsbsc_pkg::L_TX;
        tsbsc_pkg::L_IGNORE: state_nxt = tsbsc_pkg::L_IGNORE;
        default:             state_nxt = tsbsc_pkg::L_IGNORE;
      endcase
    end else begin
      cnt_nxt   = cnt_r + 4'd1;
      shift_nxt = byte_w;
      if (cnt_r == 4'd7) begin
        case (state_r)
          tsbsc_pkg::L_ADDR: begin
            rw_nxt  = byte_w[0];
            ara_nxt = (byte_w[7:1] == `TSBSC_ARA_ADDR) & byte_w[0] & alert_s_r;
            ack_nxt = (byte_w[7:1] == SLAVE_ADDR) | ara_nxt;
          end
          tsbsc_pkg::L_CMD: begin
            cmd_nxt = byte_w;
            ctg_nxt = ~ctg_r;
            ack_nxt = 1'b1;
          end
          tsbsc_pkg::L_DATA: begin
            dat_nxt = byte_w;
            dtg_nxt = ~dtg_r;
            ack_nxt = 1'b1;
          end
          default: ack_nxt = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge smb_clk_i or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      state_r <= tsbsc_pkg::L_ADDR;
      cnt_r   <= 4'd0;
      shift_r <= 8'h00;
      ack_r   <= 1'b0;
      rw_r    <= 1'b0;
      ara_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shift_r <= shift_nxt;
      ack_r   <= ack_nxt;
      rw_r    <= rw_nxt;
      ara_r   <= ara_nxt;
    end
  end

  always_comb begin
    drv_nxt = 1'b0;
    tx_nxt  = tx_r;
    if (state_r == tsbsc_pkg::L_TX) begin
      if (cnt_r == 4'd0) begin
        drv_nxt = ~tx_src[7];
        tx_nxt  = {tx_src[6:0], 1'b0};
      end else if (cnt_r != 4'd8) begin
        drv_nxt = ~tx_r[7];
        tx_nxt  = {tx_r[6:0], 1'b0};
      end
    end else begin
      drv_nxt = ack_r & (cnt_r == 4'd8);
    end
  end

  always_ff @(negedge smb_clk_i or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      drv_r <= 1'b0;
      tx_r  <= 8'h00;
    end else begin
      drv_r <= drv_nxt;
      tx_r  <= tx_nxt;
    end
  end
endmodule : tsbsc_link
`default_nettype wire

// >>> rtl/tsbsc_top.sv
/*
 Serial slave, register set and standby/conversion control of a two-channel
 temperature sensor. The bit engine runs on the serial clock; registers,
 conversion timing and standby run on clk_i.
 Assumes open-drain pins are resolved outside, measurements arrive on clk_i
 in quarter degrees, and the serial clock low phase exceeds three clk_i cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tsbsc_defines.svh"
module tsbsc_top #(
  parameter int unsigned CONV_CYCLES = `TSBSC_CONV_CYCLES,
  parameter int unsigned RATE_CYCLES = `TSBSC_RATE_CYCLES,
  parameter logic [6:0]  SLAVE_ADDR  = `TSBSC_SLAVE_ADDR_DFLT
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  // Serial bus pins
  input  wire logic               smb_clk_i,
  input  wire logic               smb_data_i,
  output logic                    smb_data_o,
  output logic                    smb_data_oe_o,
  // Alert pin, open drain
  output logic                    alert_n_o,
  output logic                    alert_n_oe_o,
  // Standby pin
  input  wire logic               standby_request_pin_n_i,
  // Measurements, quarter degrees
  input  wire logic signed [10:0] local_meas_i,
  input  wire logic signed [10:0] remote_meas_i,
  // Status
  output logic                    standby_o,
  output logic                    conv_busy_o
);
  tsbsc_link_if link_if ();

  tsbsc_link #(
    .SLAVE_ADDR (SLAVE_ADDR)
  ) u_link (
    .smb_clk_i  (smb_clk_i),
    .rst_n_i    (resetn_i),
    .smb_data_i (smb_data_i),
    .lnk        (link_if.engine)
  );

  function automatic logic [7:0] round_temp(input logic signed [10:0] m);
    logic signed [11:0] s;
    logic signed [9:0]  t;
    s = {m[10], m} + `TSBSC_ROUND_HALF;
    t = s[11:2];
    if (t > `TSBSC_CLAMP_HI) begin
      round_temp = 8'(`TSBSC_CLAMP_HI);
    end else if (t < `TSBSC_CLAMP_LO) begin
      round_temp = 8'(`TSBSC_CLAMP_LO);
    end else begin
      round_temp = t[7:0];
    end
  endfunction : round_temp

  // Synchronisers; first stages are read only by second stages.
  logic       scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r, standby_request_pin_n_m_r, standby_request_pin_n_s_r;
  logic [2:0] tgl_m_r, tgl_s_r, tgl_d_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_m_r  <= 1'b1;
      scl_s_r  <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_m_r  <= 1'b1;
      sda_s_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      standby_request_pin_n_m_r <= 1'b1;
      standby_request_pin_n_s_r <= 1'b1;
      tgl_m_r  <= 3'h0;
      tgl_s_r  <= 3'h0;
      tgl_d_r  <= 3'h0;
    end else begin
      scl_m_r  <= smb_clk_i;
      scl_s_r  <= scl_m_r;
      scl_d_r  <= scl_s_r;
      sda_m_r  <= smb_data_i;
      sda_s_r  <= sda_m_r;
      sda_d_r  <= sda_s_r;
      standby_request_pin_n_m_r <= standby_request_pin_n_i;
      standby_request_pin_n_s_r <= standby_request_pin_n_m_r;
      tgl_m_r  <= {link_if.ara_tgl, link_if.dat_tgl, link_if.cmd_tgl};
      tgl_s_r  <= tgl_m_r;
      tgl_d_r  <= tgl_s_r;
    end
  end

  logic start_cond, stop_cond, evt_cmd, evt_dat, evt_ara, oneshot, halt_wr;
  logic tick, start_conv, conv_done, alarm;

  assign start_cond = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_cond  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign evt_cmd    = tgl_s_r[0] ^ tgl_d_r[0];
  assign evt_dat    = tgl_s_r[1] ^ tgl_d_r[1];
  assign evt_ara    = tgl_s_r[2] ^ tgl_d_r[2];
  assign oneshot    = evt_cmd & (link_if.cmd_byte == `TSBSC_CMD_ONESHOT);

  // Core state.
  logic                    hold_r, hold_nxt, frame_r, frame_nxt, alert_r, alert_nxt, os_r, os_nxt;
  tsbsc_pkg::tsbsc_cstate_t cst_r, cst_nxt;
  logic [31:0]             conv_cnt_r, conv_cnt_nxt, rate_cnt_r, rate_cnt_nxt;
  logic [7:0]              ptr_r, ptr_nxt, rd_r, rd_nxt, cfg_r, cfg_nxt, rate_r, rate_nxt;
  logic [7:0]              lhi_r, lhi_nxt, llo_r, llo_nxt, rhi_r, rhi_nxt, rlo_r, rlo_nxt;
  logic [7:0]              tloc_r, tloc_nxt, trem_r, trem_nxt, st_r, st_nxt, sel, nl, nr;

  always_comb begin
    hold_nxt     = hold_r;
    frame_nxt    = frame_r;
    alert_nxt    = alert_r;
    os_nxt       = os_r;
    cst_nxt      = cst_r;
    conv_cnt_nxt = conv_cnt_r;
    rate_cnt_nxt = rate_cnt_r;
    ptr_nxt      = ptr_r;
    rd_nxt       = rd_r;
    cfg_nxt      = cfg_r;
    rate_nxt     = rate_r;
    lhi_nxt      = lhi_r;
    llo_nxt      = llo_r;
    rhi_nxt      = rhi_r;
    rlo_nxt      = rlo_r;
    tloc_nxt     = tloc_r;
    trem_nxt     = trem_r;
    st_nxt       = st_r;
    start_conv   = 1'b0;
    conv_done    = 1'b0;
    alarm        = 1'b0;
    halt_wr      = 1'b0;
    nl           = round_temp(local_meas_i);
    nr           = round_temp(remote_meas_i);

    // Engine held in reset from start or stop until the clock falls.
    if (start_cond | stop_cond) begin
      hold_nxt = 1'b1;
    end else if (!scl_s_r) begin
      hold_nxt = 1'b0;
    end
    if (start_cond) begin
      frame_nxt = 1'b1;
    end else if (stop_cond) begin
      frame_nxt = 1'b0;
    end

    if (evt_cmd & ~oneshot) begin
      ptr_nxt = link_if.cmd_byte;
    end

    if (evt_dat) begin
      case (ptr_r)
        `TSBSC_CMD_WR_CFG: begin
          cfg_nxt = link_if.dat_byte;
          halt_wr = link_if.dat_byte[`TSBSC_CFG_HALT_BIT];
        end
        `TSBSC_CMD_WR_RATE: rate_nxt = link_if.dat_byte;
        `TSBSC_CMD_WR_LHI:  lhi_nxt  = link_if.dat_byte;
        `TSBSC_CMD_WR_LLO:  llo_nxt  = link_if.dat_byte;
        `TSBSC_CMD_WR_RHI:  rhi_nxt  = link_if.dat_byte;
        `TSBSC_CMD_WR_RLO:  rlo_nxt  = link_if.dat_byte;
        default:            cfg_nxt  = cfg_r;
      endcase
    end

    if (rate_cnt_r == 32'(RATE_CYCLES - 1)) begin
      rate_cnt_nxt = 32'h0;
    end else begin
      rate_cnt_nxt = rate_cnt_r + 32'h1;
    end
    tick = (rate_cnt_r == 32'(RATE_CYCLES - 1));

    case (cst_r)
      tsbsc_pkg::C_IDLE: begin
        if (standby_request_pin_n_s_r & (os_r | (tick & ~cfg_r[`TSBSC_CFG_HALT_BIT]))) begin
          start_conv   = 1'b1;
          cst_nxt      = tsbsc_pkg::C_BUSY;
          conv_cnt_nxt = 32'h0;
        end
      end
      tsbsc_pkg::C_BUSY: begin
        if (~standby_request_pin_n_s_r | halt_wr) begin
          cst_nxt      = tsbsc_pkg::C_IDLE;
          conv_cnt_nxt = 32'h0;
        end else if (conv_cnt_r == 32'(CONV_CYCLES - 1)) begin
          conv_done    = 1'b1;
          cst_nxt      = tsbsc_pkg::C_IDLE;
          conv_cnt_nxt = 32'h0;
        end else begin
          conv_cnt_nxt = conv_cnt_r + 32'h1;
        end
      end
      default: begin
        cst_nxt      = tsbsc_pkg::C_IDLE;
        conv_cnt_nxt = 32'h0;
      end
    endcase

    if (oneshot & standby_request_pin_n_s_r) begin
      os_nxt = 1'b1;
    end else if (start_conv | ~standby_request_pin_n_s_r) begin
      os_nxt = 1'b0;
    end

    if (conv_done) begin
      tloc_nxt = nl;
      trem_nxt = nr;
      st_nxt[`TSBSC_ST_LHI_BIT] = $signed(nl) >= $signed(lhi_r);
      st_nxt[`TSBSC_ST_LLO_BIT] = $signed(nl) <= $signed(llo_r);
      st_nxt[`TSBSC_ST_RHI_BIT] = $signed(nr) >= $signed(rhi_r);
      st_nxt[`TSBSC_ST_RLO_BIT] = $signed(nr) <= $signed(rlo_r);
      alarm = (st_nxt[`TSBSC_ST_LHI_BIT] | st_nxt[`TSBSC_ST_LLO_BIT] |
               st_nxt[`TSBSC_ST_RHI_BIT] | st_nxt[`TSBSC_ST_RLO_BIT]) & ~cfg_r[`TSBSC_CFG_MASK_BIT];
    end
    st_nxt[`TSBSC_ST_BUSY_BIT] = (cst_nxt == tsbsc_pkg::C_BUSY);

    if (alarm) begin
      alert_nxt = 1'b1;
    end else if (evt_ara) begin
      alert_nxt = 1'b0;
    end

    // Read byte is frozen within a frame, except on a command byte, so the engine sees a stable word.
    sel = (evt_cmd & ~oneshot) ? link_if.cmd_byte : ptr_r;
    if (~frame_r | evt_cmd) begin
      case (sel)
        `TSBSC_CMD_RD_LOCAL:  rd_nxt = tloc_r;
        `TSBSC_CMD_RD_REMOTE: rd_nxt = trem_r;
        `TSBSC_CMD_RD_STATUS: rd_nxt = st_r;
        `TSBSC_CMD_RD_CFG:    rd_nxt = cfg_r;
        `TSBSC_CMD_RD_RATE:   rd_nxt = rate_r;
        `TSBSC_CMD_RD_LHI:    rd_nxt = lhi_r;
        `TSBSC_CMD_RD_LLO:    rd_nxt = llo_r;
        `TSBSC_CMD_RD_RHI:    rd_nxt = rhi_r;
        `TSBSC_CMD_RD_RLO:    rd_nxt = rlo_r;
        default:              rd_nxt = `TSBSC_RD_DFLT;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_r     <= 1'b1;
      frame_r    <= 1'b0;
      alert_r    <= 1'b0;
      os_r       <= 1'b0;
      cst_r      <= tsbsc_pkg::C_IDLE;
      conv_cnt_r <= 32'h0;
      rate_cnt_r <= 32'h0;
      ptr_r      <= `TSBSC_CMD_RD_LOCAL;
      rd_r       <= `TSBSC_TEMP_POR;
      cfg_r      <= `TSBSC_CFG_POR;
      rate_r     <= `TSBSC_RATE_POR;
      lhi_r      <= `TSBSC_THI_POR;
      llo_r      <= `TSBSC_TLO_POR;
      rhi_r      <= `TSBSC_THI_POR;
      rlo_r      <= `TSBSC_TLO_POR;
      tloc_r     <= `TSBSC_TEMP_POR;
      trem_r     <= `TSBSC_TEMP_POR;
      st_r       <= 8'h00;
    end else begin
      hold_r     <= hold_nxt;
      frame_r    <= frame_nxt;
      alert_r    <= alert_nxt;
      os_r       <= os_nxt;
      cst_r      <= cst_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      rate_cnt_r <= rate_cnt_nxt;
      ptr_r      <= ptr_nxt;
      rd_r       <= rd_nxt;
      cfg_r      <= cfg_nxt;
      rate_r     <= rate_nxt;
      lhi_r      <= lhi_nxt;
      llo_r      <= llo_nxt;
      rhi_r      <= rhi_nxt;
      rlo_r      <= rlo_nxt;
      tloc_r     <= tloc_nxt;
      trem_r     <= trem_nxt;
      st_r       <= st_nxt;
    end
  end

  assign link_if.frame_rst_n = ~hold_r;
  assign link_if.rd_byte     = rd_r;
  assign link_if.alert_lvl   = alert_r;

  // Open-drain pins only ever pull low.
  assign smb_data_o    = 1'b0;
  assign smb_data_oe_o = link_if.sda_oe;
  assign alert_n_o     = 1'b0;
  assign alert_n_oe_o  = alert_r;
  assign standby_o     = ~standby_request_pin_n_s_r | cfg_r[`TSBSC_CFG_HALT_BIT];
  assign conv_busy_o   = (cst_r == tsbsc_pkg::C_BUSY);
endmodule : tsbsc_top
`default_nettype wire

// >>> tb/tsbsc_assertions.sv
/* Port checker of the sensor slave top.
   Assumes binding to tsbsc_top with its conversion count. */
`timescale 1ns/1ps
`default_nettype none
module tsbsc_assertions #(
  parameter int unsigned CONV_CYCLES = 50
) (
  // Top ports
  input wire logic               clk_i,
  input wire logic               resetn_i,
  input wire logic               smb_clk_i,
  input wire logic               smb_data_i,
  input wire logic               smb_data_o,
  input wire logic               smb_data_oe_o,
  input wire logic               alert_n_o,
  input wire logic               alert_n_oe_o,
  input wire logic               standby_request_pin_n_i,
  input wire logic signed [10:0] local_meas_i,
  input wire logic signed [10:0] remote_meas_i,
  input wire logic               standby_o,
  input wire logic               conv_busy_o
);
  int unsigned bcnt_r;
  int unsigned bcnt_nxt;
  always_comb bcnt_nxt = conv_busy_o ? bcnt_r + 1 : 0;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) bcnt_r <= 0;
    else bcnt_r <= bcnt_nxt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // The pin passes two sync flops, so five low samples leave margin.
  sequence s_pin_low;
    !standby_request_pin_n_i [*5];
  endsequence
  sequence s_ack_rise;
    $rose(smb_data_oe_o);
  endsequence
  AST_DATA_OD: assert property (smb_data_o == 1'b0)
    else $error("data pin driven high");
  AST_ALERT_OD: assert property (alert_n_o == 1'b0)
    else $error("alert pin driven high");
  AST_PIN_STANDBY_REQUEST_PIN_N: assert property (s_pin_low |-> standby_o)
    else $error("pin low without standby");
  AST_PIN_NO_CONV: assert property (s_pin_low |-> !$rose(conv_busy_o))
    else $error("conversion started with pin low");
  AST_ABORT: assert property ($fell(standby_request_pin_n_i) && conv_busy_o |-> ##[1:5] !conv_busy_o)
    else $error("conversion not aborted");
  AST_CONV_MAX: assert property (conv_busy_o |-> bcnt_r <= CONV_CYCLES)
    else $error("conversion too long");
  AST_OE_CLK_LOW: assert property ($changed(smb_data_oe_o) |-> !smb_clk_i)
    else $error("data changed while clock high");
  AST_ACK_STANDS: assert property (s_ack_rise |=> smb_data_oe_o [*3])
    else $error("driven bit too short");
  AST_ALERT_LATCH: assert property ($rose(alert_n_oe_o) |=> alert_n_oe_o [*8])
    else $error("alert not latched");
endmodule : tsbsc_assertions
bind tsbsc_top tsbsc_assertions #(.CONV_CYCLES(CONV_CYCLES)) u_tsbsc_assertions (
  .clk_i(clk_i), .resetn_i(resetn_i), .smb_clk_i(smb_clk_i), .smb_data_i(smb_data_i),
  .smb_data_o(smb_data_o), .smb_data_oe_o(smb_data_oe_o), .alert_n_o(alert_n_o),
  .alert_n_oe_o(alert_n_oe_o), .standby_request_pin_n_i(standby_request_pin_n_i),
  .local_meas_i(local_meas_i), .remote_meas_i(remote_meas_i), .standby_o(standby_o),
  .conv_busy_o(conv_busy_o));
`default_nettype wire

// >>> tb/tsbsc_host.sv
/* Bus master model: 64 ns serial clock, idle high, pulled-up data.
   Assumes the device pulls data low only through its enable. */
`timescale 1ns/1ps
`default_nettype none
module tsbsc_host (
  // Device enable
  input  wire logic dev_oe_i,
  // Bus wires
  output logic      scl_o,
  output logic      sda_o
);
  logic low_r;
  // Pull-up, so a released line reads high.
  assign sda_o = !(low_r || dev_oe_i);
  initial begin
    scl_o = 1'b1;
    low_r = 1'b0;
  end
  task automatic start;
    #3.3;
    low_r = 1'b0;
    #20 scl_o = 1'b1;
    #50 low_r = 1'b1;
    #50 scl_o = 1'b0;
  endtask : start
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #20 low_r = !tx[i];
      #20 scl_o = 1'b1;
      #12 rx[i] = sda_o;
      #12 scl_o = 1'b0;
    end
  endtask : xfer
  // one master only, so frames never interleave.
  task automatic stop;
    low_r = 1'b1;
    #20 scl_o = 1'b1;
    #50 low_r = 1'b0;
    #50;
  endtask : stop
endmodule : tsbsc_host
`default_nettype wire

// >>> tb/tsbsc_top_tb.sv
/* Self-checking bench of the sensor slave and standby control.
   Assumes the host model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module tsbsc_top_tb;
  localparam int unsigned CONV = 50;
  // Slave address value is arbitrary.
  localparam logic [6:0] SADR = 7'h35;
  localparam logic [7:0] POR [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
  logic clk_i, resetn_i, scl, sda, oe, dout, aoe, an, pin_n, standby_request_pin_n, busy;
  logic signed [10:0] lm, rm;
  logic [8:0] r;
  logic [7:0] rd_b, d, t0;
  logic [7:0] exp_q [$];
  int errors, checks_done, n, m, seed, bl;
  event rd_ev;
  tsbsc_top #(.CONV_CYCLES(CONV), .RATE_CYCLES(200), .SLAVE_ADDR(SADR)) u_tsbsc_top (
    .clk_i(clk_i), .resetn_i(resetn_i), .smb_clk_i(scl), .smb_data_i(sda), .smb_data_o(dout),
    .smb_data_oe_o(oe), .alert_n_o(an), .alert_n_oe_o(aoe), .standby_request_pin_n_i(pin_n),
    .local_meas_i(lm), .remote_meas_i(rm), .standby_o(standby_request_pin_n), .conv_busy_o(busy));
  tsbsc_host u_tsbsc_host (.dev_oe_i(oe), .scl_o(scl), .sda_o(sda));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Busy length in clock cycles; the conversion may already run when a task returns.
  always @(posedge clk_i) bl <= busy ? bl + 1 : 0;
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic tx(input logic [7:0] b);
    u_tsbsc_host.xfer({b, 1'b1}, r);
    chk(8'h00, {7'h0, r[0]});
  endtask : tx
  task automatic cmd(input logic [7:0] c);
    u_tsbsc_host.start();
    tx({SADR, 1'b0});
    tx(c);
  endtask : cmd
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_tsbsc_host.start();
    tx({a, 1'b1});
    u_tsbsc_host.xfer(9'h1ff, r);
    rd_b = r[8:1];
    ->rd_ev;
    u_tsbsc_host.stop();
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    cmd(c);
    tx(v);
    u_tsbsc_host.stop();
  endtask : wr
  task automatic wt(input logic v);
    n = 0;
    while (busy !== v && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wt
  function automatic logic [7:0] rnd(input int q);
    int t;
    t = (q + 2) >>> 2;
    if (t > 127) t = 127;
    if (t < -65) t = -65;
    return t[7:0];
  endfunction : rnd
  task automatic conv(output logic [7:0] e);
    @(negedge clk_i);
    m = $urandom_range(800) - 280;
    lm = m[10:0];
    rm = 11'(-m);
    e = rnd(m);
    cmd(8'h0f);
    u_tsbsc_host.stop();
    wt(1'b1);
  endtask : conv
  task automatic end_sim;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    forever begin
      @(rd_ev);
      chk(exp_q.pop_front(), rd_b);
    end
  end
  initial begin
    #300us;
    errors++;
    end_sim();
  end
  initial begin
    errors = 0;
    checks_done = 0;
    resetn_i = 1'b0;
    pin_n = 1'b0;
    lm = '0;
    rm = '0;
    seed = $urandom(48429);
    repeat (16) @(posedge clk_i);
    @(negedge clk_i) resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    // Power-on values while the pin holds standby.
    for (int i = 0; i < 9; i++) begin
      cmd(8'(i));
      rd(SADR, POR[i]);
    end
    rd(SADR, 8'hc9);
    d = 8'($urandom);
    wr(8'h0d, d);
    cmd(8'h07);
    rd(SADR, d);
    wr(8'h0b, 8'h80);
    u_tsbsc_host.start();
    u_tsbsc_host.xfer({~SADR, 2'b01}, r);
    chk(8'h01, {7'h0, r[0]});
    u_tsbsc_host.stop();
    conv(t0);
    chk(8'h00, {7'h0, busy});
    wr(8'h09, 8'h40);
    @(negedge clk_i) pin_n = 1'b1;
    repeat (300) @(negedge clk_i);
    chk(8'h02, {6'h0, standby_request_pin_n, busy});
    conv(t0);
    wt(1'b0);
    chk(8'(CONV), bl[7:0]);
    cmd(8'h00);
    rd(SADR, t0);
    cmd(8'h01);
    rd(SADR, rnd(-m));
    conv(d);
    repeat (10) @(negedge clk_i);
    pin_n = 1'b0;
    wt(1'b0);
    @(negedge clk_i) pin_n = 1'b1;
    cmd(8'h00);
    rd(SADR, t0);
    chk(8'h01, {7'h0, aoe});
    rd(7'h0c, {SADR, 1'b1});
    chk(8'h00, {7'h0, aoe});
    wr(8'h09, 8'h00);
    wt(1'b1);
    chk(8'h01, {7'h0, busy});
    end_sim();
  end
endmodule : tsbsc_top_tb
`default_nettype wire
